/* File: verilog/oesc_pkg.sv */
package oesc_pkg;

   // =====================================================================
   // register map (word indices on the plain register port)
   localparam logic [5:0] OESC_ADDR_PWR_ONE = 6'h01;
   localparam logic [5:0] OESC_ADDR_PWR_THREE = 6'h03;
   localparam logic [5:0] OESC_ADDR_ADD_CTRL = 6'h07;
   localparam logic [5:0] OESC_ADDR_GP_CTRL = 6'h08;
   localparam logic [5:0] OESC_ADDR_BOOST_CTRL = 6'h09;
   localparam logic [5:0] OESC_ADDR_MONO_MIX = 6'h0A;
   localparam logic [5:0] OESC_ADDR_TIEOFF = 6'h31;
   localparam logic [5:0] OESC_ADDR_IRQ_STAT = 6'h20;
   localparam logic [5:0] OESC_ADDR_IRQ_EN = 6'h21;
   localparam logic [5:0] OESC_ADDR_IRQ_CLR = 6'h22;
   localparam logic [5:0] OESC_ADDR_OUT_STAT = 6'h23;

   // =====================================================================
   // field positions
   localparam int OESC_B_TIEOFF_BUF = 2;
   localparam int OESC_B_LVL_DRV = 8;
   localparam int OESC_B_BIAS = 3;
   localparam int OESC_B_SPK_MIX = 2;
   localparam int OESC_B_MONO_MIX = 3;
   localparam int OESC_B_SPK_POS = 5;
   localparam int OESC_B_SPK_NEG = 6;
   localparam int OESC_B_MONO_OUT = 7;
   localparam int OESC_B_RES_SEL = 0;
   localparam int OESC_B_OVERTEMP = 1;
   localparam int OESC_B_SLOW_TICK = 0;
   localparam int OESC_B_GP_INVERT = 3;
   localparam int OESC_B_TWO_WIRE = 4;
   localparam int OESC_B_SPK_SHIFT = 0;
   localparam int OESC_B_MONO_SHIFT = 1;
   localparam int OESC_B_MONO_SILENCE = 6;
   localparam int OESC_IRQ_THERMAL = 0;
   localparam int OESC_IRQ_JACK = 1;

   localparam logic [2:0] OESC_GP_FN_SWITCH = 3'h1;

   // =====================================================================
   // reset values
   localparam logic [8:0] OESC_RST_ZERO = 9'h000;
   localparam logic [8:0] OESC_RST_TIEOFF = 9'h002;
   localparam logic [8:0] OESC_RST_GP = 9'h010;
   localparam logic [8:0] OESC_RST_MONO_MIX = 9'h000;
   localparam logic [1:0] OESC_IRQ_ZERO = 2'h0;

   // =====================================================================
   // timing: slow tick period is 2^21 master clock periods
   localparam int OESC_SLOW_LOG2 = 21;
   localparam logic [20:0] OESC_SLOW_LAST = 21'h1FFFFF;

   typedef struct packed {
      logic res_sel;       // 0: about 1 kohm, 1: about 30 kohm
      logic high_level;    // 1: tie or sit at 1.5x half-supply
   } oesc_tie_s;

   typedef struct packed {
      logic speaker_pos_en;
      logic speaker_neg_en;
      logic mono_out_en;
      logic speaker_mixer_en;
      logic mono_mixer_en;
      logic tieoff_buffer_en;
      logic level_shift_driver_en;
      logic amp_bias_en;
      logic mono_out_silence;
      logic overtemp_protect_en;
      oesc_tie_s speaker_tie;
      oesc_tie_s mono_tie;
   } oesc_analog_s;

endpackage : oesc_pkg

/* File: verilog/oesc_debounce.sv */
`timescale 1ns/1ps
module oesc_debounce
   import oesc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tick_en,
   input wire logic raw_in,
   output logic level,
   output logic changed
);

   typedef struct packed {
      logic [20:0] div;
      logic sync1;
      logic sync2;
      logic cand;
      logic stable;
      logic chg;
   } oesc_db_s;

   oesc_db_s s_q;
   oesc_db_s s_d;
   logic tick;

   // =====================================================================
   // slow tick divider and debounce
   always_comb begin
      s_d = s_q;
      s_d.chg = 1'b0;
      s_d.sync1 = raw_in;
      s_d.sync2 = s_q.sync1;
      tick = 1'b0;
      if (tick_en) begin
         s_d.div = s_q.div + 21'h000001;
         tick = (s_q.div == OESC_SLOW_LAST);
      end else begin
         s_d.div = '0;
      end
      if (tick) begin
         s_d.cand = s_q.sync2;
         // a level must be seen on two ticks in a row before it is taken
         if (s_q.sync2 == s_q.cand && s_q.cand != s_q.stable) begin
            s_d.stable = s_q.cand;
            s_d.chg = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.stable;
   assign changed = s_q.chg;

endmodule : oesc_debounce

/* File: verilog/oesc_ctrl.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ps
module oesc_ctrl
   import oesc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] reg_addr,
   input wire logic [8:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [8:0] reg_rdata,
   input wire logic chip_select_gp_pin,
   input wire logic overtemp_in,
   output oesc_analog_s analog_q,
   output logic switch_mode_q,
   output logic slow_tick_en_q,
   output logic irq_q
);

   typedef struct packed {
      logic [8:0] pwr_one;
      logic [8:0] pwr_three;
      logic [8:0] add_ctrl;
      logic [8:0] gp_ctrl;
      logic [8:0] boost;
      logic [8:0] mono_mix;
      logic [8:0] tieoff;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic temp_q;
      logic [8:0] rdata;
      oesc_analog_s ana;
      logic sw_mode;
      logic irq;
   } oesc_state_s;

   oesc_state_s s_q;
   oesc_state_s s_d;
   logic sw_level;
   logic sw_changed;
   logic sw_mode;
   logic jack_in;
   logic spk_allow;
   logic mono_allow;
   logic [1:0] ev;
   logic [1:0] clr;

   // =====================================================================
   // jack detect debounce
   oesc_debounce u_debounce (
      .clk(clk),
      .rst_b(rst_b),
      .tick_en(s_q.add_ctrl[OESC_B_SLOW_TICK]),
      .raw_in(chip_select_gp_pin),
      .level(sw_level),
      .changed(sw_changed)
   );

   // =====================================================================
   // next state
   always_comb begin
      s_d = s_q;
      clr = '0;
      // switch input only when the control port runs two-wire
      sw_mode = s_q.gp_ctrl[OESC_B_TWO_WIRE]
         && (s_q.gp_ctrl[2:0] == OESC_GP_FN_SWITCH);
      jack_in = sw_level ^ s_q.gp_ctrl[OESC_B_GP_INVERT];
      // the switch only masks; it never sets an enable on its own
      spk_allow = !sw_mode || jack_in;
      mono_allow = !sw_mode || !jack_in;

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            OESC_ADDR_PWR_ONE: s_d.pwr_one = reg_wdata;
            OESC_ADDR_PWR_THREE: s_d.pwr_three = reg_wdata;
            OESC_ADDR_ADD_CTRL: s_d.add_ctrl = reg_wdata;
            OESC_ADDR_GP_CTRL: s_d.gp_ctrl = reg_wdata;
            OESC_ADDR_BOOST_CTRL: s_d.boost = reg_wdata;
            OESC_ADDR_MONO_MIX: s_d.mono_mix = reg_wdata;
            OESC_ADDR_TIEOFF: s_d.tieoff = reg_wdata;
            OESC_ADDR_IRQ_EN: s_d.irq_en = reg_wdata[1:0];
            OESC_ADDR_IRQ_CLR: clr = reg_wdata[1:0];
            default: ;
         endcase
      end

      // register reads, data valid the cycle after the strobe
      s_d.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            OESC_ADDR_PWR_ONE: s_d.rdata = s_q.pwr_one;
            OESC_ADDR_PWR_THREE: s_d.rdata = s_q.pwr_three;
            OESC_ADDR_ADD_CTRL: s_d.rdata = s_q.add_ctrl;
            OESC_ADDR_GP_CTRL: s_d.rdata = s_q.gp_ctrl;
            OESC_ADDR_BOOST_CTRL: s_d.rdata = s_q.boost;
            OESC_ADDR_MONO_MIX: s_d.rdata = s_q.mono_mix;
            OESC_ADDR_TIEOFF: s_d.rdata = s_q.tieoff;
            OESC_ADDR_IRQ_STAT: s_d.rdata = {7'h00, s_q.irq_stat};
            OESC_ADDR_IRQ_EN: s_d.rdata = {7'h00, s_q.irq_en};
            OESC_ADDR_OUT_STAT: s_d.rdata = {4'h0, sw_level, s_q.sw_mode,
               s_q.ana.speaker_pos_en, s_q.ana.speaker_neg_en, s_q.ana.mono_out_en};
            default: s_d.rdata = '0;
         endcase
      end

      // sticky events; a set in the clearing cycle wins
      s_d.temp_q = overtemp_in;
      ev[OESC_IRQ_THERMAL] = overtemp_in && !s_q.temp_q
         && s_q.tieoff[OESC_B_OVERTEMP];
      ev[OESC_IRQ_JACK] = sw_changed && sw_mode;
      s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
      s_d.irq = |(s_d.irq_stat & s_d.irq_en);

      // analogue controls, all active high
      s_d.sw_mode = sw_mode;
      s_d.ana.tieoff_buffer_en = s_q.pwr_one[OESC_B_TIEOFF_BUF];
      s_d.ana.level_shift_driver_en = s_q.pwr_one[OESC_B_LVL_DRV];
      s_d.ana.amp_bias_en = s_q.pwr_one[OESC_B_BIAS];
      s_d.ana.speaker_mixer_en = s_q.pwr_three[OESC_B_SPK_MIX];
      s_d.ana.mono_mixer_en = s_q.pwr_three[OESC_B_MONO_MIX];
      s_d.ana.speaker_pos_en = s_q.pwr_three[OESC_B_SPK_POS] && spk_allow;
      s_d.ana.speaker_neg_en = s_q.pwr_three[OESC_B_SPK_NEG] && spk_allow;
      s_d.ana.mono_out_en = s_q.pwr_three[OESC_B_MONO_OUT] && mono_allow;
      // silenced mono drives the speaker dc offset as headphone ground
      s_d.ana.mono_out_silence = s_q.mono_mix[OESC_B_MONO_SILENCE];
      s_d.ana.overtemp_protect_en = s_q.tieoff[OESC_B_OVERTEMP];
      // the resistance field is passed always; the analogue side uses it
      // only while the matching enable is low
      s_d.ana.speaker_tie.res_sel = s_q.tieoff[OESC_B_RES_SEL];
      s_d.ana.speaker_tie.high_level = s_q.boost[OESC_B_SPK_SHIFT];
      s_d.ana.mono_tie.res_sel = s_q.tieoff[OESC_B_RES_SEL];
      // a silenced mono must follow the speaker level, not its own
      s_d.ana.mono_tie.high_level = s_q.mono_mix[OESC_B_MONO_SILENCE]
         ? s_q.boost[OESC_B_SPK_SHIFT] : s_q.boost[OESC_B_MONO_SHIFT];
   end

   // =====================================================================
   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.pwr_one <= OESC_RST_ZERO;
         s_q.pwr_three <= OESC_RST_ZERO;
         s_q.add_ctrl <= OESC_RST_ZERO;
         s_q.gp_ctrl <= OESC_RST_GP;
         s_q.mono_mix <= OESC_RST_MONO_MIX;
         s_q.tieoff <= OESC_RST_TIEOFF;
         s_q.irq_stat <= OESC_IRQ_ZERO;
         s_q.irq_en <= OESC_IRQ_ZERO;
         s_q.ana.overtemp_protect_en <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign analog_q = s_q.ana;
   assign switch_mode_q = s_q.sw_mode;
   assign slow_tick_en_q = s_q.add_ctrl[OESC_B_SLOW_TICK];
   assign irq_q = s_q.irq;

endmodule : oesc_ctrl

/* File: verif/oesc_ctrl_chk.sv */
`timescale 1ns/1ps
module oesc_ctrl_chk
   import oesc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] reg_addr,
   input wire logic [8:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [8:0] reg_rdata,
   input wire logic chip_select_gp_pin,
   input wire logic overtemp_in,
   input wire oesc_analog_s analog_q,
   input wire logic switch_mode_q,
   input wire logic slow_tick_en_q,
   input wire logic irq_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // =====================================================================
   // assertions and cover points
   a_reset_outs_off: assert property ($rose(rst_b) |->
      !(analog_q.speaker_pos_en | analog_q.mono_out_en | analog_q.speaker_mixer_en)
      && analog_q.overtemp_protect_en) else $error("outputs not off after reset");
   a_tieoff_buf_bit: assert property (reg_wr && reg_addr == OESC_ADDR_PWR_ONE |->
      ##2 analog_q.tieoff_buffer_en == $past(reg_wdata[2], 2)) else $error("tieoff buffer");
   a_level_drv_bit: assert property (reg_wr && reg_addr == OESC_ADDR_PWR_ONE |->
      ##2 analog_q.level_shift_driver_en == $past(reg_wdata[8], 2)) else $error("level drv");
   a_mixer_en_bits: assert property (reg_wr && reg_addr == OESC_ADDR_PWR_THREE |->
      ##2 {analog_q.mono_mixer_en, analog_q.speaker_mixer_en} == $past(reg_wdata[3:2], 2)
      ) else $error("mixer enables");
   a_tie_res_sel: assert property (reg_wr && reg_addr == OESC_ADDR_TIEOFF |->
      ##2 analog_q.speaker_tie.res_sel == $past(reg_wdata[0], 2)) else $error("res sel");
   a_overtemp_bit: assert property (reg_wr && reg_addr == OESC_ADDR_TIEOFF |->
      ##2 analog_q.overtemp_protect_en == $past(reg_wdata[1], 2)) else $error("overtemp en");
   a_slow_tick_bit: assert property (reg_wr && reg_addr == OESC_ADDR_ADD_CTRL |->
      ##2 slow_tick_en_q == $past(reg_wdata[0], 2)) else $error("slow tick enable");
   a_mono_silence: assert property (reg_wr && reg_addr == OESC_ADDR_MONO_MIX |->
      ##2 analog_q.mono_out_silence == $past(reg_wdata[6], 2)) else $error("mono silence");
   a_switch_mask: assert property (switch_mode_q |->
      !(analog_q.speaker_pos_en && analog_q.mono_out_en)) else $error("switch lets both on");
   c_pwr_three: cover property (reg_wr && reg_addr == OESC_ADDR_PWR_THREE);
   c_irq_up: cover property ($rose(irq_q));
   c_switch_on: cover property ($rose(switch_mode_q));
endmodule : oesc_ctrl_chk

bind oesc_ctrl oesc_ctrl_chk oesc_ctrl_chk_i (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .chip_select_gp_pin, .overtemp_in, .analog_q, .switch_mode_q,
   .slow_tick_en_q, .irq_q);

/* File: verif/oesc_jack_model.sv */
`timescale 1ns/1ps
// =====================================================================
// jack contact and die sensor; the contact opens when a plug goes in
module oesc_jack_model (
   input wire logic plugged,
   input wire logic hot,
   output logic gp_pin,
   output logic overtemp
);
   assign gp_pin = !plugged;
   assign overtemp = hot;
endmodule : oesc_jack_model

/* File: verif/oesc_ctrl_tb.sv */
`timescale 1ns/1ps
module oesc_ctrl_tb
   import oesc_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [8:0] reg_wdata = 9'h000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic plugged = 1'b0;
   logic hot = 1'b0;
   logic [8:0] reg_rdata;
   logic gp_pin, overtemp, switch_mode_q, slow_tick_en_q, irq_q;
   oesc_analog_s analog_q;
   logic [7:0] en;
   int error_cnt = 0;
   int num_checks = 0;
   int sel_bit[5] = '{3, 2, 7, 6, 5};
   assign en = {analog_q.speaker_pos_en, analog_q.speaker_neg_en, analog_q.mono_out_en,
      analog_q.speaker_mixer_en, analog_q.mono_mixer_en, analog_q.tieoff_buffer_en,
      analog_q.level_shift_driver_en, analog_q.amp_bias_en};
   initial begin
      forever #20 clk = ~clk;
   end
   oesc_jack_model oesc_jack_model_i (.plugged, .hot, .gp_pin, .overtemp);
   oesc_ctrl oesc_ctrl_i (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .chip_select_gp_pin(gp_pin), .overtemp_in(overtemp), .analog_q, .switch_mode_q,
      .slow_tick_en_q, .irq_q);
   // =====================================================================
   // bus, check and end-of-run tasks
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [8:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // analog_q lags the strobe by two edges; two spare edges keep writes apart
      repeat (3) @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [8:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   // =====================================================================
   // tests
   initial begin
      #100us;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({1'b0, en}, 9'h000);
      chk(9'(analog_q.overtemp_protect_en), 9'h001);
      rd(OESC_ADDR_TIEOFF, 9'h002);
      rd(OESC_ADDR_PWR_ONE, 9'h000);
      rd(OESC_ADDR_PWR_THREE, 9'h000);
      rd(6'h3F, 9'h000);
      $display("test reset done");
      wr(OESC_ADDR_PWR_ONE, 9'h10C);
      chk({1'b0, en}, 9'h007);
      wr(OESC_ADDR_PWR_THREE, 9'h0EC);
      chk({1'b0, en}, 9'h0FF);
      rd(OESC_ADDR_PWR_THREE, 9'h0EC);
      for (int i = 0; i < 5; i++) begin
         wr(OESC_ADDR_PWR_THREE, 9'h001 << sel_bit[i]);
         chk({1'b0, en}, (9'h001 << (i + 3)) | 9'h007);
      end
      $display("test enables done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({1'b0, en}, 9'h000);
      rd(OESC_ADDR_PWR_THREE, 9'h000);
      $display("test second reset done");
      wr(OESC_ADDR_TIEOFF, 9'h001);
      wr(OESC_ADDR_BOOST_CTRL, 9'h003);
      chk(9'({analog_q.speaker_tie, analog_q.mono_tie}), 9'h00F);
      chk(9'(analog_q.overtemp_protect_en), 9'h000);
      wr(OESC_ADDR_MONO_MIX, 9'h040);
      chk(9'(analog_q.mono_out_silence), 9'h001);
      wr(OESC_ADDR_BOOST_CTRL, 9'h001);
      chk(9'(analog_q.mono_tie.high_level), 9'h001);
      wr(OESC_ADDR_ADD_CTRL, 9'h001);
      chk(9'(slow_tick_en_q), 9'h001);
      wr(OESC_ADDR_ADD_CTRL, 9'h000);
      $display("test tieoff done");
      wr(OESC_ADDR_PWR_THREE, 9'h080);
      wr(OESC_ADDR_GP_CTRL, 9'h011);
      chk(9'(switch_mode_q), 9'h001);
      chk({6'h00, en[7:5]}, 9'h001);
      wr(OESC_ADDR_GP_CTRL, 9'h019);
      chk({6'h00, en[7:5]}, 9'h000);
      wr(OESC_ADDR_PWR_THREE, 9'h0E0);
      chk({6'h00, en[7:5]}, 9'h006);
      @(posedge clk);
      plugged <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      // no slow tick runs, so the debounced level must hold
      chk({6'h00, en[7:5]}, 9'h006);
      @(posedge clk);
      plugged <= 1'b0;
      wr(OESC_ADDR_GP_CTRL, 9'h001);
      chk(9'(switch_mode_q), 9'h000);
      chk({6'h00, en[7:5]}, 9'h007);
      $display("test switch done");
      wr(OESC_ADDR_TIEOFF, 9'h002);
      @(posedge clk);
      hot <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk(9'(irq_q), 9'h000);
      rd(OESC_ADDR_IRQ_STAT, 9'h001);
      wr(OESC_ADDR_IRQ_EN, 9'h001);
      chk(9'(irq_q), 9'h001);
      wr(OESC_ADDR_IRQ_CLR, 9'h001);
      chk(9'(irq_q), 9'h000);
      rd(OESC_ADDR_IRQ_CLR, 9'h000);
      @(posedge clk);
      hot <= 1'b0;
      $display("test interrupt done");
      end_sim;
   end
endmodule : oesc_ctrl_tb
